// File: design/fpecc_pkg.sv
// Constants and carrier types of the flash prefetch ECC status block
package fpecc_pkg;

    // =====================================================
    // Register map (byte offsets, each register is one word)
    localparam int ADDR_W = 8;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h10;
    localparam logic [7:0] IRQ_STS_OFS = 8'h20;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h30;
    localparam logic [7:0] BASE_MASK = 8'hf0;

    // =====================================================
    // Alias selector in address bits 3:2
    typedef enum logic [1:0] {
        FPECC_AL_WRITE = 2'b00,
        FPECC_AL_CLR = 2'b01,
        FPECC_AL_SET = 2'b10,
        FPECC_AL_INV = 2'b11
    } fpecc_alias_e;

    // =====================================================
    // Reset values and implemented-bit masks
    localparam logic [31:0] CTRL_RST = 32'h0000_0007;
    localparam logic [31:0] CTRL_MASK = 32'h0400_0037;
    localparam logic [31:0] STAT_RST = 32'h0000_0000;
    localparam logic [31:0] STAT_MASK = 32'h0c00_00ff;

    // =====================================================
    // Field positions
    localparam int SEC_EN_BIT = 26;
    localparam int PFE_LSB = 4;
    localparam int PFE_W = 2;
    localparam int WS_LSB = 0;
    localparam int WS_W = 3;
    localparam int DED_BIT = 27;
    localparam int SEC_BIT = 26;
    localparam int CNT_LSB = 0;
    localparam int CNT_W = 8;
    localparam int IRQ_W = 2;
    localparam int IRQ_DED_BIT = 0;
    localparam int IRQ_SEC_BIT = 1;

    // =====================================================
    // Carriers
    typedef struct packed {
        logic ded;
        logic sec;
    } fpecc_evt_s;

    typedef struct packed {
        logic [PFE_W-1:0] prefetch_enable_field;
        logic [WS_W-1:0] flash_wait_states;
    } fpecc_cfg_s;

endpackage

// File: design/fpecc_top.sv
// Flash prefetch control word, ECC error flags, corrected-error counter, APB slave
`timescale 1ns/1ps

// What this block does
// - Every register except interrupt status has clear, set and invert aliases at plus 0x4, 0x8, 0xC.
// - Reset: control reads 0x00000007, status reads all zeros.
// - Double-error flag set by hardware, cleared only by a software write or alias write that leaves the bit zero.
// - Corrected flag sets only on a corrected error while counter is zero.
// - Counter decrements by one for each corrected error.
// - Counter holds at zero instead of wrapping.
// - Software may load any counter value; counting resumes from it.
// - Corrected flag with its enable raises the interrupt.
// - Every corrected error counts, repeated addresses included.
// - Unimplemented status bits read zero and ignore writes.
module fpecc_top
    import fpecc_pkg::*;
(
    // Clock, reset, enable
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // ECC decoder events, one-cycle pulses
    input wire fpecc_evt_s ecc_evt,
    // Prefetch configuration to the flash path
    output fpecc_cfg_s pf_cfg,
    // Interrupt request
    output logic irq
);

    // =====================================================
    // Functions

    // Applies a plain write or an alias operation
    function automatic logic [31:0] alias_apply(input fpecc_alias_e op, input logic [31:0] old,
                                                input logic [31:0] data);
        logic [31:0] r;
        r = data;
        unique case (op)
            FPECC_AL_WRITE: r = data;
            FPECC_AL_CLR: r = old & ~data;
            FPECC_AL_SET: r = old | data;
            FPECC_AL_INV: r = old ^ data;
        endcase
        return r;
    endfunction

    // Status word assembled from flags and counter
    function automatic logic [31:0] stat_word(input logic d, input logic s, input logic [CNT_W-1:0] c);
        logic [31:0] r;
        r = STAT_RST;
        r[DED_BIT] = d;
        r[SEC_BIT] = s;
        r[CNT_LSB +: CNT_W] = c;
        return r;
    endfunction

    // =====================================================
    // State
    logic [31:0] ctrl;
    logic ded_flag;
    logic sec_flag;
    logic [CNT_W-1:0] sec_cnt;
    logic [IRQ_W-1:0] irq_sts;
    logic [IRQ_W-1:0] irq_mask;
    logic cap_q;
    logic [31:0] rd_q;
    logic err_q;

    // =====================================================
    // Address decode
    wire [7:0] ofs = paddr[7:0];
    wire [7:0] base_ofs = ofs & BASE_MASK;
    wire fpecc_alias_e alias_op = fpecc_alias_e'(ofs[3:2]);
    wire aligned = (ofs[1:0] == 2'h0);
    wire hit_ctrl = aligned && (base_ofs == CTRL_OFS);
    wire hit_stat = aligned && (base_ofs == STAT_OFS);
    wire hit_isr = aligned && (base_ofs == IRQ_STS_OFS);
    wire hit_imask = aligned && (base_ofs == IRQ_MASK_OFS);
    wire hit_any = hit_ctrl || hit_stat || hit_isr || hit_imask;

    // Transfer completes one ce cycle into the access phase
    assign pready = psel && penable && ce && cap_q;
    wire wr = pready && pwrite;
    wire wr_ctrl = wr && hit_ctrl;
    wire wr_stat = wr && hit_stat;
    wire wr_isr = wr && hit_isr && (alias_op == FPECC_AL_WRITE);
    wire wr_imask = wr && hit_imask;

    // =====================================================
    // Read mux
    wire [31:0] stat_old = stat_word(ded_flag, sec_flag, sec_cnt);
    wire [31:0] rd_mux = hit_ctrl ? ctrl :
                         hit_stat ? stat_old :
                         hit_isr ? {{(32-IRQ_W){1'b0}}, irq_sts} :
                         hit_imask ? {{(32-IRQ_W){1'b0}}, irq_mask} : 32'h0000_0000;

    // =====================================================
    // Next values of the registers
    // alias operation applied to the addressed register
    wire [31:0] ctrl_w = alias_apply(alias_op, ctrl, pwdata) & CTRL_MASK;
    wire [31:0] stat_w = alias_apply(alias_op, stat_old, pwdata) & STAT_MASK;
    wire [31:0] mask_w = alias_apply(alias_op, {{(32-IRQ_W){1'b0}}, irq_mask}, pwdata);

    // a software load replaces the count before the event acts
    wire [CNT_W-1:0] cnt_base = wr_stat ? stat_w[CNT_LSB +: CNT_W] : sec_cnt;
    wire cnt_zero = (cnt_base == '0);
    // flag event only when the count already stands at zero
    wire sec_at_zero = ecc_evt.sec && cnt_zero;
    // decrement by one per corrected error
    // no address filter, every pulse counts
    wire [CNT_W-1:0] next_cnt = (ecc_evt.sec && !cnt_zero) ? cnt_base - 1'b1 : cnt_base;
    // software may only clear the flag
    wire ded_sw_clr = wr_stat && !stat_w[DED_BIT];
    wire sec_sw_clr = wr_stat && !stat_w[SEC_BIT];
    // hardware set wins over a software clear
    wire next_ded = ecc_evt.ded || (ded_flag && !ded_sw_clr);
    wire next_sec = sec_at_zero || (sec_flag && !sec_sw_clr);

    // Sticky interrupt events, write one to clear, set wins
    wire [IRQ_W-1:0] isr_evt = {sec_at_zero, ecc_evt.ded};
    wire [IRQ_W-1:0] isr_clr = wr_isr ? pwdata[IRQ_W-1:0] : '0;
    wire [IRQ_W-1:0] next_irq_sts = isr_evt | (irq_sts & ~isr_clr);

    // =====================================================
    // Control register
    // control resets to seven wait states
    always_ff @(posedge clock) begin
        if (!nrst) begin
            ctrl <= CTRL_RST;
        end else if (ce && wr_ctrl) begin
            ctrl <= ctrl_w;
        end
    end

    // Status flags and counter
    // status resets to zero
    always_ff @(posedge clock) begin
        if (!nrst) begin
            ded_flag <= STAT_RST[DED_BIT];
            sec_flag <= STAT_RST[SEC_BIT];
            sec_cnt <= STAT_RST[CNT_LSB +: CNT_W];
        end else if (ce) begin
            ded_flag <= next_ded;
            sec_flag <= next_sec;
            sec_cnt <= next_cnt;
        end
    end

    // Interrupt status and mask
    always_ff @(posedge clock) begin
        if (!nrst) begin
            irq_sts <= '0;
            irq_mask <= '0;
        end else if (ce) begin
            irq_sts <= next_irq_sts;
            if (wr_imask) begin
                irq_mask <= mask_w[IRQ_W-1:0];
            end
        end
    end

    // Read data and error captured every ce cycle, selected or not
    always_ff @(posedge clock) begin
        if (!nrst) begin
            cap_q <= 1'b0;
            rd_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end else if (ce) begin
            cap_q <= psel && !pready;
            rd_q <= rd_mux;
            err_q <= !hit_any;
        end
    end

    // =====================================================
    // Outputs
    assign prdata = rd_q;
    assign pslverr = pready && err_q;
    assign pf_cfg.prefetch_enable_field = ctrl[PFE_LSB +: PFE_W];
    assign pf_cfg.flash_wait_states = ctrl[WS_LSB +: WS_W];
    // enabled corrected flag requests an interrupt
    assign irq = (sec_flag && ctrl[SEC_EN_BIT]) || (|(irq_sts & irq_mask));

    // =====================================================
    // Assertions
    default clocking cb @(posedge clock iff ce);
    endclocking
    default disable iff (!nrst);

    sequence s_stat_quiet;
        !wr_stat && ecc_evt.sec;
    endsequence

    a_reset_values: assert property (
        disable iff (1'b0) !nrst |=> (ctrl == CTRL_RST) && (stat_old == STAT_RST))
        else $error("reset values wrong");

    a_alias_set: assert property (
        wr_ctrl && (alias_op == FPECC_AL_SET) |=> ctrl == (($past(ctrl) | $past(pwdata)) & CTRL_MASK))
        else $error("set alias failed");

    a_ded_sticky: assert property (
        ded_flag && !wr_stat |=> ded_flag)
        else $error("double-error flag lost");

    a_set_wins: assert property (
        ecc_evt.ded || sec_at_zero |=> ($past(ecc_evt.ded) -> ded_flag) && ($past(sec_at_zero) -> sec_flag))
        else $error("hardware set lost");

    a_sec_cause: assert property (
        $rose(sec_flag) |-> $past(ecc_evt.sec) && $past(cnt_zero))
        else $error("corrected flag without zero count");

    a_cnt_dec: assert property (
        s_stat_quiet ##0 (sec_cnt != '0) |=> sec_cnt == $past(sec_cnt) - 1'b1)
        else $error("counter did not decrement");

    a_cnt_sat: assert property (
        s_stat_quiet ##0 (sec_cnt == '0) |=> (sec_cnt == '0) && sec_flag)
        else $error("counter wrapped");

    a_cnt_load: assert property (
        wr_stat && (alias_op == FPECC_AL_WRITE) && !ecc_evt.sec |=> sec_cnt == $past(pwdata[CNT_W-1:0]))
        else $error("counter load failed");

    a_unimpl_zero: assert property (
        pready && !pwrite && hit_stat |-> (prdata & ~STAT_MASK) == 32'h0000_0000)
        else $error("unimplemented bits nonzero");

    a_irq_level: assert property (
        sec_flag && ctrl[SEC_EN_BIT] |-> irq)
        else $error("interrupt missing");

    a_irq_drop: assert property (
        sec_sw_clr && !sec_at_zero && !(|(next_irq_sts & irq_mask)) && !wr_ctrl |=> !irq)
        else $error("interrupt did not drop");

endmodule

// File: verification/fpecc_flash_model.sv
// ECC decoder model feeding error events to the status block
`timescale 1ns/1ps
module fpecc_flash_model
    import fpecc_pkg::*;
(
    // Clock
    input wire logic clock,
    // Error events to the block
    output fpecc_evt_s ecc_evt
);
    // =====================================================
    // Event source
    // Quiet until an error is reported
    initial begin
        ecc_evt = '0;
    end

    // repeated errors
    // Report n errors back to back, one per cycle
    task automatic emit(input fpecc_evt_s kind, input int n);
        ecc_evt <= kind;
        repeat (n) @(posedge clock);
        ecc_evt <= '0;
    endtask
endmodule

// File: verification/fpecc_top_tb.sv
// Self-checking bench of the flash prefetch ECC status block
`timescale 1ns/1ps
module fpecc_top_tb
    import fpecc_pkg::*;
;
    // =====================================================
    // Signals
    localparam fpecc_evt_s sec_evt = 2'b01;
    localparam fpecc_evt_s ded_evt = 2'b10;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, irq, err;
    fpecc_evt_s ecc_evt;
    fpecc_cfg_s pf_cfg;
    int bad_count = 0;
    int tests_run = 0;
    int cycles = 0;

    always #20 clock = ~clock;

    fpecc_top i_fpecc_top (.clock(clock), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ecc_evt(ecc_evt),
        .pf_cfg(pf_cfg), .irq(irq));
    fpecc_flash_model i_fpecc_flash_model (.clock(clock), .ecc_evt(ecc_evt));

    // =====================================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (bad_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // One transfer; an idle edge first keeps back-to-back calls clean
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // Completion is sampled at the rising edge only
        @(posedge clock);
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, '0);
        check(rd, exp);
    endtask

    // Interrupt follows its cause one cycle late
    task automatic irqchk(input logic e);
        repeat (2) @(negedge clock);
        check({31'h0, irq}, {31'h0, e});
    endtask

    // Hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            conclude();
        end
    end

    // =====================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        rdchk(CTRL_OFS, CTRL_RST);
        rdchk(STAT_OFS, STAT_RST);
        check({29'h0, pf_cfg.flash_wait_states}, 32'h7);
        apb(1'b1, CTRL_OFS + 8'h08, 32'h0400_0030);
        rdchk(CTRL_OFS, 32'h0400_0037);
        apb(1'b1, CTRL_OFS + 8'h04, 32'h0000_0003);
        rdchk(CTRL_OFS + 8'h04, 32'h0400_0034);
        apb(1'b1, CTRL_OFS + 8'h0c, 32'h0000_0007);
        rdchk(CTRL_OFS, 32'h0400_0033);
        check({30'h0, pf_cfg.prefetch_enable_field}, 32'h3);
        apb(1'b1, STAT_OFS, 32'hffff_ffff);
        rdchk(STAT_OFS, 32'h0000_00ff);
        i_fpecc_flash_model.emit(sec_evt, 3);
        rdchk(STAT_OFS, 32'h0000_00fc);
        apb(1'b1, STAT_OFS, 32'h0000_0001);
        i_fpecc_flash_model.emit(sec_evt, 1);
        rdchk(STAT_OFS, 32'h0);
        irqchk(1'b0);
        i_fpecc_flash_model.emit(sec_evt, 2);
        rdchk(STAT_OFS, 32'h0400_0000);
        irqchk(1'b1);
        i_fpecc_flash_model.emit(ded_evt, 1);
        apb(1'b1, STAT_OFS, 32'h0c00_0000);
        rdchk(STAT_OFS, 32'h0c00_0000);
        fork
            apb(1'b1, STAT_OFS, 32'h0);
            begin
                // Event sampled at the same edge as the clearing write
                repeat (2) @(posedge clock);
                i_fpecc_flash_model.emit(ded_evt, 1);
            end
        join
        rdchk(STAT_OFS, 32'h0800_0000);
        irqchk(1'b0);
        apb(1'b1, STAT_OFS + 8'h04, 32'h0800_0000);
        rdchk(STAT_OFS, 32'h0);
        rdchk(IRQ_STS_OFS, 32'h3);
        apb(1'b1, IRQ_STS_OFS, 32'h3);
        rdchk(IRQ_STS_OFS, 32'h0);
        apb(1'b1, IRQ_MASK_OFS, 32'h1);
        i_fpecc_flash_model.emit(ded_evt, 1);
        irqchk(1'b1);
        apb(1'b1, IRQ_STS_OFS, 32'h1);
        irqchk(1'b0);
        apb(1'b1, IRQ_MASK_OFS + 8'h04, 32'h1);
        i_fpecc_flash_model.emit(ded_evt, 1);
        irqchk(1'b0);
        rdchk(IRQ_STS_OFS, 32'h1);
        apb(1'b0, 8'h40, '0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        conclude();
    end
endmodule
